// >>> hw/csr_charger_status_regs.sv
// module: read-only charger status registers behind the serial control bus
// How it works
// - status one bit 0 shows adapter detection completed.
// - status two bits 7-6: optimizer disabled, running, found; 3 reserved.
// - status two bit 2 shows die thermal regulation.
// - status two bit 1 high only while data-line detection runs.
// - status two bit 0 shows battery above undervoltage-release level.
// - status three bit 7 shows input two blocking pair fitted.
// - status three bit 6 shows input one blocking pair fitted.
// - status three bit 5 shows one-shot ADC conversion complete.
// - status three bit 4 shows forward-mode minimum system regulation.
// - status three bits 3,2,1: fast, trickle, pre-charge timers expired.
// - status four bit 4 shows battery too low for boost.
// - status four bit 3 shows thermistor cold zone.
// - status four bit 2 shows thermistor cool zone.
// - status four bit 1 shows thermistor warm zone.
// - status four bit 0 shows thermistor hot zone.
`timescale 1ns/1ps
module csr_charger_status_regs (
  input wire logic core_clk_in, // 250 mhz core clock
  input wire logic rst_in, // synchronous reset, active high
  input wire csr_pkg::csr_req_s req_in, // register read or write request
  input wire csr_pkg::csr_src_s src_in, // internal status conditions
  output logic [7:0] rdata_out, // read data, valid cycle after rd
  output logic rvalid_out, // one-cycle read answer strobe
  output logic [7:0] status_one_out, // live status one image
  output logic [7:0] status_two_out, // live status two image
  output logic [7:0] status_three_out, // live status three image
  output logic [7:0] status_four_out // live status four image
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
    logic [7:0] four;
    logic [7:0] rdata;
    logic rvalid;
  } csr_state_s;

  csr_state_s st_ff;
  csr_state_s nxt_st;

  function automatic logic [7:0] csr_read(
    input logic [7:0] addr,
    input csr_state_s s
  );
    logic [7:0] d;
    d = csr_pkg::RST_RDATA;
    if (addr == csr_pkg::OFS_STATUS_ONE) begin
      d = s.one;
    end else if (addr == csr_pkg::OFS_STATUS_TWO) begin
      d = s.two;
    end else if (addr == csr_pkg::OFS_STATUS_THREE) begin
      d = s.three;
    end else if (addr == csr_pkg::OFS_STATUS_FOUR) begin
      d = s.four;
    end
    return d;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    // images rebuilt every cycle from zero, so reserved bits stay low
    nxt_st.one = csr_pkg::RST_STATUS;
    nxt_st.two = csr_pkg::RST_STATUS;
    nxt_st.three = csr_pkg::RST_STATUS;
    nxt_st.four = csr_pkg::RST_STATUS;
    nxt_st.one[csr_pkg::ONE_DETECT_DONE_BIT] =
      src_in.adapter_detect_done;
    // reserved code never reported, shown as disabled instead
    if (src_in.input_current_optimizer_state !=
        csr_pkg::CSR_OPT_RESERVED) begin
      nxt_st.two[csr_pkg::TWO_OPT_LSB +: 2] =
        src_in.input_current_optimizer_state;
    end
    nxt_st.two[csr_pkg::TWO_THERMAL_BIT] =
      src_in.thermal_regulation_active;
    nxt_st.two[csr_pkg::TWO_DATA_LINE_BIT] =
      src_in.data_line_detect_running;
    nxt_st.two[csr_pkg::TWO_BAT_PRESENT_BIT] =
      src_in.battery_present;
    nxt_st.three[csr_pkg::THREE_IN2_PAIR_BIT] =
      src_in.input2_blocking_pair_fitted;
    nxt_st.three[csr_pkg::THREE_IN1_PAIR_BIT] =
      src_in.input1_blocking_pair_fitted;
    // completion only means something in one-shot mode
    nxt_st.three[csr_pkg::THREE_ADC_DONE_BIT] =
      src_in.adc_oneshot_mode & src_in.adc_conversion_done;
    nxt_st.three[csr_pkg::THREE_MIN_SYS_BIT] =
      src_in.forward_mode & src_in.min_system_regulation_active;
    nxt_st.three[csr_pkg::THREE_FAST_TMR_BIT] =
      src_in.fast_charge_timer_expired;
    nxt_st.three[csr_pkg::THREE_TRICKLE_TMR_BIT] =
      src_in.trickle_timer_expired;
    nxt_st.three[csr_pkg::THREE_PRE_TMR_BIT] =
      src_in.precharge_timer_expired;
    nxt_st.four[csr_pkg::FOUR_BAT_LOW_BIT] =
      src_in.battery_low_for_boost;
    nxt_st.four[csr_pkg::FOUR_COLD_BIT] =
      src_in.thermistor_cold_zone;
    nxt_st.four[csr_pkg::FOUR_COOL_BIT] =
      src_in.thermistor_cool_zone;
    nxt_st.four[csr_pkg::FOUR_WARM_BIT] =
      src_in.thermistor_warm_zone;
    nxt_st.four[csr_pkg::FOUR_HOT_BIT] =
      src_in.thermistor_hot_zone;
    // req_in.wr deliberately unused: nothing here is writable
    nxt_st.rvalid = req_in.rd;
    nxt_st.rdata = req_in.rd ? csr_read(req_in.addr, st_ff) :
      csr_pkg::RST_RDATA;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;
  assign rvalid_out = st_ff.rvalid;
  assign status_one_out = st_ff.one;
  assign status_two_out = st_ff.two;
  assign status_three_out = st_ff.three;
  assign status_four_out = st_ff.four;

endmodule

// >>> hw/csr_pkg.sv
// package: register map, field positions and status carriers for charger status
package csr_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_STATUS_ONE = 8'h1c;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h1d;
  localparam logic [7:0] OFS_STATUS_THREE = 8'h1e;
  localparam logic [7:0] OFS_STATUS_FOUR = 8'h1f;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ONE_DETECT_DONE_BIT = 0;
  localparam int TWO_OPT_LSB = 6;
  localparam int TWO_THERMAL_BIT = 2;
  localparam int TWO_DATA_LINE_BIT = 1;
  localparam int TWO_BAT_PRESENT_BIT = 0;
  localparam int THREE_IN2_PAIR_BIT = 7;
  localparam int THREE_IN1_PAIR_BIT = 6;
  localparam int THREE_ADC_DONE_BIT = 5;
  localparam int THREE_MIN_SYS_BIT = 4;
  localparam int THREE_FAST_TMR_BIT = 3;
  localparam int THREE_TRICKLE_TMR_BIT = 2;
  localparam int THREE_PRE_TMR_BIT = 1;
  localparam int FOUR_BAT_LOW_BIT = 4;
  localparam int FOUR_COLD_BIT = 3;
  localparam int FOUR_COOL_BIT = 2;
  localparam int FOUR_WARM_BIT = 1;
  localparam int FOUR_HOT_BIT = 0;

  // ************************************************************
  // optimizer codes
  // ************************************************************
  typedef enum logic [1:0] {
    CSR_OPT_DISABLED = 2'b00,
    CSR_OPT_RUNNING = 2'b01,
    CSR_OPT_FOUND = 2'b10,
    CSR_OPT_RESERVED = 2'b11
  } csr_opt_e;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic adapter_detect_done;
    csr_opt_e input_current_optimizer_state;
    logic thermal_regulation_active;
    logic data_line_detect_running;
    logic battery_present;
    logic input2_blocking_pair_fitted;
    logic input1_blocking_pair_fitted;
    logic adc_oneshot_mode;
    logic adc_conversion_done;
    logic forward_mode;
    logic min_system_regulation_active;
    logic fast_charge_timer_expired;
    logic trickle_timer_expired;
    logic precharge_timer_expired;
    logic battery_low_for_boost;
    logic thermistor_cold_zone;
    logic thermistor_cool_zone;
    logic thermistor_warm_zone;
    logic thermistor_hot_zone;
  } csr_src_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_req_s;

endpackage

// >>> verification/csr_host.sv
// partner: host issuing single register accesses to the status block
`timescale 1ns/1ps
module csr_host (
  input wire logic core_clk_in, // core clock
  input wire logic rvalid_in, // read answer strobe
  input wire logic [7:0] rdata_in, // read data
  output csr_pkg::csr_req_s req_out // access request
);
  initial req_out = '0;
  // request held across exactly one taking edge, then answer captured
  task automatic access(input logic wr, input logic [7:0] a,
                        output logic [8:0] d);
    @(posedge core_clk_in) #1;
    req_out = '{rd: !wr, wr: wr, addr: a, wdata: ~a};
    @(posedge core_clk_in) #1;
    d = {rvalid_in, rdata_in};
    req_out = '0;
  endtask
endmodule

// >>> verification/csr_status_assertions.sv
// checker: port relations of the charger status registers
`timescale 1ns/1ps
module csr_status_assertions (
  input wire logic core_clk_in, // core clock
  input wire logic rst_in, // synchronous reset, active high
  input wire csr_pkg::csr_req_s req_in, // host request
  input wire csr_pkg::csr_src_s src_in, // status sources
  input wire logic [7:0] rdata_out, // read data
  input wire logic rvalid_out, // read answer strobe
  input wire logic [7:0] status_one_out, // status one image
  input wire logic [7:0] status_two_out, // status two image
  input wire logic [7:0] status_three_out, // status three image
  input wire logic [7:0] status_four_out // status four image
);
  csr_pkg::csr_src_s p_ff;
  logic live_ff;
  // live_ff masks the first edge after reset, where images are still zero
  always_ff @(posedge core_clk_in) begin
    p_ff <= src_in;
    live_ff <= !rst_in;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(a);
    req_in.rd && req_in.addr == a;
  endsequence
  a_rd_answer: assert property (req_in.rd |=> rvalid_out)
    else $error("read not answered");
  a_idle_quiet: assert property (
    !req_in.rd |=> !rvalid_out && rdata_out == 8'h00)
    else $error("answer without read");
  a_rd_unmapped: assert property (
    req_in.rd && req_in.addr[7:2] != 6'h07 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rd_three: assert property (
    s_rd(csr_pkg::OFS_STATUS_THREE) |=>
      rdata_out == $past(status_three_out))
    else $error("read data differs from image");
  a_one_img: assert property (
    live_ff |-> status_one_out == {7'h00, p_ff.adapter_detect_done})
    else $error("status one wrong");
  a_opt_field: assert property (
    live_ff |-> status_two_out[7:6] ==
      (p_ff.input_current_optimizer_state == csr_pkg::CSR_OPT_RESERVED ?
       2'h0 : p_ff.input_current_optimizer_state))
    else $error("optimizer field wrong");
  a_two_img: assert property (
    live_ff |-> status_two_out[5:0] == {3'h0,
      p_ff.thermal_regulation_active, p_ff.data_line_detect_running,
      p_ff.battery_present})
    else $error("status two wrong");
  a_three_img: assert property (
    live_ff |-> status_three_out == {p_ff.input2_blocking_pair_fitted,
      p_ff.input1_blocking_pair_fitted,
      p_ff.adc_oneshot_mode & p_ff.adc_conversion_done,
      p_ff.forward_mode & p_ff.min_system_regulation_active,
      p_ff.fast_charge_timer_expired, p_ff.trickle_timer_expired,
      p_ff.precharge_timer_expired, 1'b0})
    else $error("status three wrong");
  a_four_img: assert property (
    live_ff |-> status_four_out == {3'h0, p_ff.battery_low_for_boost,
      p_ff.thermistor_cold_zone, p_ff.thermistor_cool_zone,
      p_ff.thermistor_warm_zone, p_ff.thermistor_hot_zone})
    else $error("status four wrong");
endmodule
bind csr_charger_status_regs csr_status_assertions chk_u (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req_in),
  .src_in(src_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .status_one_out(status_one_out), .status_two_out(status_two_out),
  .status_three_out(status_three_out), .status_four_out(status_four_out));

// >>> verification/tb_top.sv
// testbench: host reads of the charger status registers
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    csr_pkg::csr_src_s s;
    logic [7:0] a;
    logic [7:0] e;
  } csr_row_s;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  csr_pkg::csr_req_s req;
  csr_pkg::csr_src_s src = '1;
  logic [7:0] rdata, img1, img2, img3, img4;
  logic rvalid;
  logic [8:0] got;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // rows: source pattern, offset, expected read data
  csr_row_s rows [19] = '{36'h800001c01, 36'h200001d40, 36'h400001d80,
    36'h600001d00, 36'h1c0001d07, 36'h030001ec0, 36'h004001e00,
    36'h00c001e20, 36'h001001e00, 36'h003001e10, 36'h000e01e0e,
    36'h000181f18, 36'h000071f07, 36'hfffff1f1f, 36'hfffff1efe,
    36'hfffff1d07, 36'hfffff1c01, 36'hfffff2000, 36'h000001d00};
  always #2 core_clk_in = ~core_clk_in;
  csr_charger_status_regs dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .req_in(req), .src_in(src), .rdata_out(rdata), .rvalid_out(rvalid),
    .status_one_out(img1), .status_two_out(img2),
    .status_three_out(img3), .status_four_out(img4));
  csr_host host_u (.core_clk_in(core_clk_in), .rvalid_in(rvalid),
    .rdata_in(rdata), .req_out(req));
  task automatic chk(input string what, input logic [8:0] seen,
                     input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_in);
    #1;
    chk("reset image", {1'b0, img1 | img2 | img3 | img4}, 9'h000);
    rst_in = 1'b0;
    foreach (rows[i]) begin
      @(posedge core_clk_in) #1 src = rows[i].s;
      host_u.access(1'b0, rows[i].a, got);
      chk("read data", got, {1'b1, rows[i].e});
    end
    src = '1;
    host_u.access(1'b1, csr_pkg::OFS_STATUS_THREE, got);
    chk("write answer", got, 9'h000);
    host_u.access(1'b0, csr_pkg::OFS_STATUS_THREE, got);
    chk("after write", got, 9'h1fe);
    host_u.access(1'b0, csr_pkg::OFS_STATUS_THREE, got);
    chk("second read", got, 9'h1fe);
    // mid-run reset must clear the status three image even with sources held high
    @(posedge core_clk_in) #1 rst_in = 1'b1;
    @(posedge core_clk_in) #1;
    chk("mid reset", {1'b0, img3}, 9'h000);
    rst_in = 1'b0;
    host_u.access(1'b0, csr_pkg::OFS_STATUS_FOUR, got);
    chk("after reset", got, 9'h11f);
    wrap_up();
  end
endmodule
